//--- hw/cfg_loader.sv
// Function
// R1 - Reset copies flash words to registers automatically
// R2 - Registers volatile, refilled after every power-up
// R3 - Calibration first, then mode, then rest
// R4 - Dual: seq1, seq2, active user, inactive protection
// R5 - Full load repeats on every reset kind
// R6 - Words fetched from top of program memory
// R7 - Image upper bytes should be zero
// R8 - Upper byte of config words ignored
// R9 - Each word at active and inactive address
// R10 - Inactive protection words govern cross-partition access
// R11 - Boot sequence word uses all 24 bits
// R12 - Mode field: 11 single, 10 dual, 01 protected
// R13 - Protected dual blocks writes to inactive partition 1
// R14 - Lower 12-bit sequence number makes partition active
// R15 - Programmer writes complement into bits 23-12
// R16 - Mode register reads ones in bits 15-2
// R17 - Active partition words configure the device
// R18 - Rest of device held in reset until loaded
module cfg_loader
    import cfg_loader_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Flash read port: address out, data returns with valid
    output logic             flash_rd_req,
    output logic [23:0]      flash_rd_addr,
    input  wire logic        flash_rd_valid,
    input  wire logic [23:0] flash_rd_data,
    // Device-wide results
    output logic             dev_reset_hold,
    output logic             active_is_p2,
    output logic             p1_write_block,
    output logic             inactive_access_block,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    load_state_t  state_r;
    load_state_t  state_nxt;
    logic [3:0]   idx_r;
    logic         req_pend_r;
    logic [23:0]  cal_r;
    logic [1:0]   mode_r;
    logic [23:0]  seq1_r;
    logic [23:0]  seq2_r;
    logic         p2_act_r;
    logic [15:0]  user_r [NUM_USER_WORDS];
    logic [15:0]  prot_r [NUM_PROT_WORDS];
    logic         sw_reload_r;
    logic         p1_block_r;
    logic         x_block_r;

    // Decoded mode and partition choice
    wire          is_dual     = (mode_r == MODE_DUAL) || (mode_r == MODE_PROT_DUAL);  // R12
    wire  [11:0]  seq1_num    = seq1_r[11:0];  // R14
    wire  [11:0]  seq2_num    = flash_rd_data[11:0];  // Second number, compared as it lands
    wire          p2_lower    = seq2_num < seq1_num;  // R14
    wire  [23:0]  act_base    = p2_act_r ? (DP_SEC_ADDR + INACTIVE_OFFSET) : DP_SEC_ADDR;  // R9
    wire  [23:0]  inact_base  = p2_act_r ? DP_SEC_ADDR : (DP_SEC_ADDR + INACTIVE_OFFSET);  // R9
    wire  [23:0]  user_base   = is_dual ? act_base : SP_SEC_ADDR;  // R6 R17
    wire  [23:0]  user_addr   = user_base + {16'h0000, USER_OFS[idx_r]};
    wire  [23:0]  prot_addr   = inact_base + {16'h0000, USER_OFS[idx_r]};  // R10
    wire          last_user   = idx_r == 4'(NUM_USER_WORDS - 1);
    wire          last_prot   = idx_r == 4'(NUM_PROT_WORDS - 1);
    wire          got         = flash_rd_valid && req_pend_r;

    // Address for the word the current state fetches
    logic [23:0] addr_sel;
    always_comb begin
        case (state_r)
            ST_CAL:  addr_sel = CAL_ADDR;  // R3
            ST_MODE: addr_sel = MODE_ADDR;  // R3
            ST_SEQ1: addr_sel = DP_SEQ_ADDR;  // R4
            ST_SEQ2: addr_sel = DP_SEQ_ADDR + INACTIVE_OFFSET;  // R4
            ST_USER: addr_sel = user_addr;
            ST_PROT: addr_sel = prot_addr;
            default: addr_sel = CAL_ADDR;
        endcase
    end

    // Load sequence; mode branch decided from the mode word as it arrives, in the cycle it is latched
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_CAL:  if (got) state_nxt = ST_MODE;
            ST_MODE: begin
                if (got) state_nxt = ((flash_rd_data[1:0] == MODE_DUAL) ||
                                      (flash_rd_data[1:0] == MODE_PROT_DUAL)) ? ST_SEQ1 : ST_USER;  // R3 R12
            end
            ST_SEQ1: if (got) state_nxt = ST_SEQ2;  // R4
            ST_SEQ2: if (got) state_nxt = ST_USER;  // R4
            ST_USER: if (got && last_user) state_nxt = is_dual ? ST_PROT : ST_DONE;  // R4
            ST_PROT: if (got && last_prot) state_nxt = ST_DONE;
            ST_DONE: if (sw_reload_r) state_nxt = ST_CAL;
            default: state_nxt = ST_CAL;
        endcase
    end

    // Every reset restarts from calibration; nothing survives it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r    <= ST_CAL;  // R1 R2 R5
            idx_r      <= 4'h0;
            req_pend_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            req_pend_r <= (state_nxt != ST_DONE) && !(got && state_nxt != state_r);
            if (state_nxt != state_r) idx_r <= 4'h0;
            else if (got) idx_r <= idx_r + 4'h1;
        end
    end

    // Captured words; upper byte of ordinary words is dropped
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cal_r    <= 24'h000000;
            mode_r   <= MODE_SINGLE;
            seq1_r   <= 24'hffffff;
            seq2_r   <= 24'hffffff;
            p2_act_r <= 1'b0;
        end else if (got) begin
            if (state_r == ST_CAL) cal_r <= flash_rd_data;
            if (state_r == ST_MODE) mode_r <= flash_rd_data[1:0];  // R12
            if (state_r == ST_SEQ1) seq1_r <= flash_rd_data;  // R11
            if (state_r == ST_SEQ2) seq2_r <= flash_rd_data;  // R11
            // Decided here so the first user address already uses the right base
            if (state_r == ST_SEQ2) p2_act_r <= p2_lower;  // R14
        end
    end

    // Word arrays, one entry per configuration word
    genvar gi;
    generate
        for (gi = 0; gi < NUM_USER_WORDS; gi++) begin : g_user
            always_ff @(posedge sys_clk) begin
                if (rst) user_r[gi] <= 16'hffff;
                else if (got && state_r == ST_USER && idx_r == 4'(gi)) user_r[gi] <= flash_rd_data[15:0];  // R8 R17
            end
        end
        for (gi = 0; gi < NUM_PROT_WORDS; gi++) begin : g_prot
            always_ff @(posedge sys_clk) begin
                if (rst) prot_r[gi] <= 16'hffff;
                else if (got && state_r == ST_PROT && idx_r == 4'(gi)) prot_r[gi] <= flash_rd_data[15:0];  // R8 R10
            end
        end
    endgenerate

    // Registered device outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flash_rd_req   <= 1'b0;
            flash_rd_addr  <= CAL_ADDR;
            dev_reset_hold <= 1'b1;
            active_is_p2   <= 1'b0;
            p1_block_r     <= 1'b0;
            x_block_r      <= 1'b0;
        end else begin
            flash_rd_req   <= (state_nxt != ST_DONE) && !got;
            flash_rd_addr  <= addr_sel;
            dev_reset_hold <= state_nxt != ST_DONE;  // R18
            active_is_p2   <= p2_act_r;
            p1_block_r     <= (mode_r == MODE_PROT_DUAL) && p2_act_r;  // R13
            x_block_r      <= is_dual && (prot_r[0][8] == 1'b0);  // R10
        end
    end
    assign p1_write_block        = p1_block_r;
    assign inactive_access_block = x_block_r;

    // AXI4-Lite write path: address and data accepted in either order
    logic       aw_got_r;
    logic       w_got_r;
    logic [7:0] aw_addr_r;
    wire        aw_fire = s_axi_awvalid && s_axi_awready;
    wire        w_fire  = s_axi_wvalid && s_axi_wready;
    wire        wr_go   = (aw_got_r || aw_fire) && (w_got_r || w_fire) && !s_axi_bvalid;
    wire  [7:0] wr_addr = aw_fire ? s_axi_awaddr : aw_addr_r;
    wire        wr_ctrl = wr_addr == REG_CTRL;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            aw_addr_r     <= 8'h00;
            sw_reload_r   <= 1'b0;
        end else begin
            sw_reload_r <= 1'b0;
            if (aw_fire) begin
                aw_got_r      <= 1'b1;
                aw_addr_r     <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_fire) begin
                w_got_r      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ctrl ? RESP_OKAY : RESP_SLVERR;
                // Reload only when idle so a running load is not torn
                sw_reload_r  <= wr_ctrl && s_axi_wstrb[0] && s_axi_wdata[0] && state_r == ST_DONE;  // R5
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read decode
    logic [31:0] rd_word;
    logic        rd_ok;
    always_comb begin
        rd_word = 32'h00000000;
        rd_ok   = 1'b1;
        if (s_axi_araddr == REG_MODE) rd_word = {16'h0000, MODE_UNIMP_ONES | {14'h0000, mode_r}};  // R16
        else if (s_axi_araddr == REG_SEQ1) rd_word = {8'h00, seq1_r};  // R11
        else if (s_axi_araddr == REG_SEQ2) rd_word = {8'h00, seq2_r};
        else if (s_axi_araddr == REG_STATUS) rd_word = {28'h0000000, p1_block_r, p2_act_r, is_dual,
                                                        state_r == ST_DONE};
        else if (s_axi_araddr == REG_CTRL) rd_word = 32'h00000000;
        else if (s_axi_araddr == REG_CAL) rd_word = {8'h00, cal_r};
        else if (s_axi_araddr >= REG_USER_BASE && s_axi_araddr < REG_USER_BASE + 8'(4 * NUM_USER_WORDS)
                 && s_axi_araddr[1:0] == 2'h0)
            rd_word = {16'h0000, user_r[4'((s_axi_araddr - REG_USER_BASE) >> 2)]};
        else if (s_axi_araddr >= REG_INACT_BASE && s_axi_araddr < REG_INACT_BASE + 8'(4 * NUM_PROT_WORDS)
                 && s_axi_araddr[1:0] == 2'h0)
            rd_word = {16'h0000, prot_r[2'((s_axi_araddr - REG_INACT_BASE) >> 2)]};
        else rd_ok = 1'b0;
    end

    // Read channel: one outstanding read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule : cfg_loader

//--- hw/cfg_loader_pkg.sv
package cfg_loader_pkg;
    // Flash word addresses, largest memory size, single partition
    localparam logic [23:0] SP_SEC_ADDR      = 24'h0abf00;
    localparam logic [23:0] SP_LIMIT_ADDR    = 24'h0abf10;
    localparam logic [23:0] SP_SIGN_ADDR     = 24'h0abf14;
    localparam logic [23:0] SP_OSCSEL_ADDR   = 24'h0abf18;
    localparam logic [23:0] SP_OSC_ADDR      = 24'h0abf1c;
    localparam logic [23:0] SP_WDT_ADDR      = 24'h0abf20;
    localparam logic [23:0] SP_POR_ADDR      = 24'h0abf24;
    localparam logic [23:0] SP_DBG_ADDR      = 24'h0abf28;
    localparam logic [23:0] SP_OPT_ADDR      = 24'h0abf2c;
    // Dual partition: partition 1 base, partition 2 base adds this offset; active and inactive swap when partition 2 is active
    localparam logic [23:0] DP_SEC_ADDR      = 24'h055f00;
    localparam logic [23:0] DP_SEQ_ADDR      = 24'h055ffc;
    localparam logic [23:0] INACTIVE_OFFSET  = 24'h400000;
    // Partition mode word location and calibration word location
    localparam logic [23:0] MODE_ADDR        = 24'h801800;
    localparam logic [23:0] CAL_ADDR         = 24'h801000;
    // Offsets of user words relative to the security word
    localparam int          NUM_USER_WORDS   = 9;
    localparam int          NUM_PROT_WORDS   = 3;
    localparam logic [7:0]  USER_OFS [NUM_USER_WORDS] = '{8'h00, 8'h10, 8'h14, 8'h18, 8'h1c,
                                                         8'h20, 8'h24, 8'h28, 8'h2c};
    // Partition mode field codes
    localparam logic [1:0]  MODE_SINGLE      = 2'h3;
    localparam logic [1:0]  MODE_DUAL        = 2'h2;
    localparam logic [1:0]  MODE_PROT_DUAL   = 2'h1;
    localparam logic [15:0] MODE_UNIMP_ONES  = 16'hfffc;
    // Register map on the AXI4-Lite slave
    localparam logic [7:0]  REG_MODE         = 8'h00;
    localparam logic [7:0]  REG_SEQ1         = 8'h04;
    localparam logic [7:0]  REG_SEQ2         = 8'h08;
    localparam logic [7:0]  REG_STATUS       = 8'h0c;
    localparam logic [7:0]  REG_CTRL         = 8'h10;
    localparam logic [7:0]  REG_CAL          = 8'h14;
    localparam logic [7:0]  REG_USER_BASE    = 8'h20;
    localparam logic [7:0]  REG_INACT_BASE   = 8'h50;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;
    // Loader states
    typedef enum logic [6:0] {
        ST_CAL   = 7'h01,
        ST_MODE  = 7'h02,
        ST_SEQ1  = 7'h04,
        ST_SEQ2  = 7'h08,
        ST_USER  = 7'h10,
        ST_PROT  = 7'h20,
        ST_DONE  = 7'h40
    } load_state_t;
endpackage : cfg_loader_pkg

//--- test/cfg_loader_chk.sv
module cfg_loader_chk
    import cfg_loader_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        flash_rd_req,
    input wire logic [23:0] flash_rd_addr,
    input wire logic        flash_rd_valid,
    input wire logic        dev_reset_hold,
    input wire logic        active_is_p2,
    input wire logic        p1_write_block,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 1ns;
    // A word changes hands when request and answer meet
    wire word_taken = flash_rd_req && flash_rd_valid;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Reset check must stay live while reset is high
    a_quiet_reset: assert property (disable iff (1'b0) rst |=> !flash_rd_req && dev_reset_hold)
        else $error("loader active in reset");
    a_start_cal: assert property ($fell(rst) |=> flash_rd_req && flash_rd_addr == CAL_ADDR)
        else $error("load did not start at calibration");
    a_cal_mode: assert property (word_taken && flash_rd_addr == CAL_ADDR
        |-> ##2 flash_rd_req && flash_rd_addr == MODE_ADDR) else $error("mode word not next");
    a_seq_pair: assert property (word_taken && flash_rd_addr == DP_SEQ_ADDR
        |-> ##2 flash_rd_req && flash_rd_addr == DP_SEQ_ADDR + INACTIVE_OFFSET) else $error("seq2 not next");
    a_req_stands: assert property (flash_rd_req && !flash_rd_valid |=> flash_rd_req && $stable(flash_rd_addr))
        else $error("flash request dropped early");
    a_req_drops: assert property (word_taken |=> !flash_rd_req)
        else $error("flash request held after answer");
    a_hold_loading: assert property (flash_rd_req |-> dev_reset_hold)
        else $error("device released during load");
    a_block_p2: assert property (p1_write_block |-> active_is_p2)
        else $error("write block while partition 1 active");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule : cfg_loader_chk

bind cfg_loader cfg_loader_chk i_cfg_loader_chk (.sys_clk, .rst, .flash_rd_req, .flash_rd_addr, .flash_rd_valid,
    .dev_reset_hold, .active_is_p2, .p1_write_block, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

//--- test/cfg_loader_tb.sv
module cfg_loader_tb
    import cfg_loader_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, rst = 1'b1;
    logic        flash_rd_req, flash_rd_valid, dev_reset_hold, active_is_p2, p1_write_block, inactive_access_block;
    logic [23:0] flash_rd_addr, flash_rd_data;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf, lat = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, mode_code = 2'h3;
    logic [11:0] seq1 = 12'h0, seq2 = 12'h0;
    int          n_fail = 0, n_checks = 0, cyc = 0, n0;
    cfg_loader i_cfg_loader (.sys_clk, .rst, .flash_rd_req, .flash_rd_addr, .flash_rd_valid, .flash_rd_data,
        .dev_reset_hold, .active_is_p2, .p1_write_block, .inactive_access_block, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    flash_model i_flash_model (.sys_clk, .rst, .flash_rd_req, .flash_rd_addr, .flash_rd_valid, .flash_rd_data,
        .mode_code, .seq1, .seq2, .lat);
    initial forever #25 sys_clk = ~sys_clk;
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask : chk
    // Write: address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask : axi_rd
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(exp, d);
    endtask : rd_chk
    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : do_reset
    // Loaded value of a plain word: upper byte gone
    function automatic logic [31:0] lo16(input logic [23:0] a);
        return {16'h0, a[15:0] ^ {a[23:16], 8'h00}};
    endfunction : lo16
    // One full load, cut once by a reset in mid-sequence
    task automatic run_case(input logic [1:0] m, input logic [11:0] s1, input logic [11:0] s2, input logic [3:0] l);
        logic        dual, p2;
        logic [23:0] act_b, inact_b;
        int          h;
        logic [23:0] exp_q[$];
        @(posedge sys_clk);
        mode_code <= m;
        seq1 <= s1;
        seq2 <= s2;
        lat <= l;
        do_reset();
        repeat (8) @(posedge sys_clk);
        do_reset();
        @(posedge sys_clk);
        while (dev_reset_hold !== 1'b0) @(posedge sys_clk);
        dual = (m == MODE_DUAL) || (m == MODE_PROT_DUAL);
        p2 = dual && (s2 < s1);
        h = dual ? 4 : 2;
        // Partition 2 active swaps the active and inactive word bases
        act_b = !dual ? SP_SEC_ADDR : (p2 ? DP_SEC_ADDR + INACTIVE_OFFSET : DP_SEC_ADDR);
        inact_b = p2 ? DP_SEC_ADDR : DP_SEC_ADDR + INACTIVE_OFFSET;
        exp_q.push_back(CAL_ADDR);
        exp_q.push_back(MODE_ADDR);
        if (dual) exp_q.push_back(DP_SEQ_ADDR);
        if (dual) exp_q.push_back(DP_SEQ_ADDR + INACTIVE_OFFSET);
        for (int i = 0; i < NUM_USER_WORDS; i++) exp_q.push_back(act_b + 24'(USER_OFS[i]));
        for (int i = 0; i < (dual ? NUM_PROT_WORDS : 0); i++) exp_q.push_back(inact_b + 24'(USER_OFS[i]));
        chk(32'(exp_q.size()), 32'(i_flash_model.log_q.size()));
        foreach (exp_q[i]) chk({8'h0, exp_q[i]}, {8'h0, i_flash_model.log_q[i]});
        chk({31'h0, p2}, {31'h0, active_is_p2});
        chk({31'h0, p2 && m == MODE_PROT_DUAL}, {31'h0, p1_write_block});
        chk({31'h0, dual}, {31'h0, inactive_access_block});
        rd_chk(REG_MODE, {16'h0, MODE_UNIMP_ONES | {14'h0, m}});
        rd_chk(REG_STATUS, {28'h0, p2 && m == MODE_PROT_DUAL, p2, dual, 1'b1});
        if (dual) rd_chk(REG_SEQ1, {8'h0, ~s1, s1});
        if (dual) rd_chk(REG_SEQ2, {8'h0, ~s2, s2});
        rd_chk(REG_CAL, lo16(CAL_ADDR) | 32'h005a0000);
        for (int i = 0; i < NUM_USER_WORDS; i++) rd_chk(REG_USER_BASE + 8'(4 * i), lo16(exp_q[h + i]));
        for (int i = 0; i < (dual ? NUM_PROT_WORDS : 0); i++) rd_chk(REG_INACT_BASE + 8'(4 * i), lo16(exp_q[13 + i]));
        $display("case with mode %h done", m);
    endtask : run_case
    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test
    // Hang guard, far above the several hundred cycles the tests take
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            chk(32'h0, 32'(cyc));
            end_of_test();
        end
    end
    initial begin
        run_case(MODE_SINGLE, 12'h010, 12'h005, 4'h0);
        run_case(MODE_DUAL, 12'h010, 12'h005, 4'h3);
        run_case(MODE_PROT_DUAL, 12'h005, 12'h005, 4'h1);
        run_case(MODE_PROT_DUAL, 12'h7ff, 12'h000, 4'h0);
        run_case(2'h0, 12'h001, 12'h000, 4'h2);
        n0 = i_flash_model.log_q.size();
        axi_wr(REG_CTRL, 32'h1, rr);
        chk({30'h0, RESP_OKAY}, {30'h0, rr});
        while (dev_reset_hold !== 1'b1) @(posedge sys_clk);
        while (dev_reset_hold !== 1'b0) @(posedge sys_clk);
        chk(32'(2 * n0), 32'(i_flash_model.log_q.size()));
        axi_wr(8'hfc, 32'h0, rr);
        chk({30'h0, RESP_SLVERR}, {30'h0, rr});
        axi_rd(8'hfc, rd, rr);
        chk({30'h0, RESP_SLVERR}, {30'h0, rr});
        chk(32'h0, rd);
        axi_wr(REG_MODE, 32'h0, rr);
        rd_chk(REG_MODE, {16'h0, MODE_UNIMP_ONES});
        $display("reload and access test done");
        end_of_test();
    end
endmodule : cfg_loader_tb

//--- test/flash_model.sv
module flash_model
    import cfg_loader_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        flash_rd_req,
    input wire logic [23:0] flash_rd_addr,
    output logic            flash_rd_valid,
    output logic [23:0]     flash_rd_data,
    input wire logic [1:0]  mode_code,
    input wire logic [11:0] seq1,
    input wire logic [11:0] seq2,
    input wire logic [3:0]  lat
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0]  wait_r;
    logic [23:0] log_q[$];
    // Upper byte nonzero on purpose, so a loader that keeps it shows up
    function automatic logic [23:0] word_at(input logic [23:0] a);
        if (a == MODE_ADDR) return {22'h0, mode_code};
        if (a == DP_SEQ_ADDR) return {~seq1, seq1};
        if (a == DP_SEQ_ADDR + INACTIVE_OFFSET) return {~seq2, seq2};
        return {8'h5a, a[15:0] ^ {a[23:16], 8'h00}};
    endfunction : word_at
    initial begin
        flash_rd_valid = 1'b0;
        flash_rd_data = 24'h0;
    end
    // Answer after lat idle cycles; released data line toggles
    always @(posedge sys_clk) begin
        if (rst) log_q.delete();
        wait_r <= (!flash_rd_req || flash_rd_valid) ? 4'h0 : wait_r + 4'h1;
        if (flash_rd_req && !flash_rd_valid && wait_r >= lat) begin
            flash_rd_valid <= 1'b1;
            flash_rd_data <= word_at(flash_rd_addr);
            log_q.push_back(flash_rd_addr);
        end else begin
            flash_rd_valid <= 1'b0;
            flash_rd_data <= ~flash_rd_data;
        end
    end
endmodule : flash_model
